/* verilog/scd_pkg.sv */
// Purpose: Shared constants, types and decode helpers for the command decoder
// Assumes: 100 MHz ref_clk; tone inputs are demodulated levels, one per tone
// Notes: Long counts are overridable through top-level parameters
package scd_pkg;

  localparam int NUM_TONES = 7;
  localparam int NUM_CHARS = 21;
  localparam int ADDR_LEN = 9;
  localparam int FUNC_LEN = 2;
  localparam int NUM_CMDS = 4;
  localparam int MSG_LEN = ADDR_LEN + FUNC_LEN;

  // Command slots in the plug's function table
  localparam int CMD_ARM = 0;
  localparam int CMD_DISP = 1;
  localparam int CMD_PWR = 2;
  localparam int CMD_SAFE = 3;

  // Word positions within a message
  localparam logic [3:0] POS_FIRST = 4'h0;
  localparam logic [3:0] POS_LAST_ADDR = 4'h8;
  localparam logic [3:0] POS_FUNC0 = 4'h9;
  localparam logic [3:0] POS_FUNC1 = 4'ha;

  // Timing in milliseconds and seconds, and derived cycle counts
  localparam int CLK_HZ = 100_000_000;
  localparam real CHAR_SLOT_MS = 8.6;
  localparam real LAST_SLOT_MS = 25.71;
  localparam real MSG_MS = 111.43;
  localparam real DISP_DELAY_S = 4.0;
  localparam int SLOT_TIMEOUT_MS = 30;
  localparam int FIRE_PULSE_MS = 1;
  localparam int SLOT_TIMEOUT_CYC = SLOT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int FIRE_PULSE_CYC = FIRE_PULSE_MS * (CLK_HZ / 1000);

  // Reset values
  localparam logic [3:0] POS_RST = 4'h0;
  localparam logic POWER_ON_RST = 1'b1;

  typedef logic [4:0] scd_char_t;

  // Code plug: nine address characters in order, two per command
  typedef struct packed {
    scd_char_t [ADDR_LEN-1:0] addr;
    scd_char_t [NUM_CMDS-1:0][FUNC_LEN-1:0] func;
  } scd_plug_t;

  typedef struct packed {
    logic arm_cutoff;
    logic fire_trigger;
    logic internal_power;
    logic power_on;
    logic safed;
  } scd_out_t;

  // Two tones at once form one of 21 characters; bit 5 flags validity
  function automatic logic [5:0] scd_decode_tones(input logic [NUM_TONES-1:0] t);
    logic [4:0] k;
    logic [5:0] r;
    int n;
    k = 5'h00;
    r = 6'h00;
    n = 0;
    for (int i = 0; i < NUM_TONES; i++)
    begin
      n = n + int'(t[i]);
    end
    for (int i = 0; i < NUM_TONES; i++)
    begin
      for (int j = i + 1; j < NUM_TONES; j++)
      begin
        if (t[i] && t[j] && n == 2)
        begin
          r = {1'b1, k};
        end
        k = k + 5'h01;
      end
    end
    return r;
  endfunction

  // True when the character is one of the nine the plug uses
  function automatic logic scd_in_code(input scd_plug_t p, input scd_char_t c);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < ADDR_LEN; i++)
    begin
      if (p.addr[i] == c)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

/* verilog/scd_sync3.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to ref_clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module scd_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
        begin
          q[i] <= s3_r[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/scd_pulse_timer.sv */
// Purpose: Fixed-length pulse stretcher for the discharge trigger
// Assumes: start is a one-cycle pulse on ref_clk
// Notes: A start during a pulse restarts it
`timescale 1ns/1ps
`default_nettype none
module scd_pulse_timer #(
  parameter int unsigned LEN_CYC = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic start,
  output logic active
);

  logic [31:0] cnt_r;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_r <= 32'h0;
    end
    else if (start)
    begin
      cnt_r <= LEN_CYC;
    end
    else if (cnt_r != 32'h0)
    begin
      cnt_r <= cnt_r - 32'h1;
    end
  end

  assign active = (cnt_r != 32'h0);

endmodule
`default_nettype wire

/* verilog/scd_decoder_ctrl.sv */
// Purpose: Secure command decoder and controller for the tank_rupture_system
// Assumes: Tones come from the command_radio_receiver; plug is static
// Notes: Safing is permanent until srst; no-safing strap disables it
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Character is two of seven tones
// - Message is nine address, two function characters
// - Function word only after full correct address
// - No character repeats within one word
// - Code plug sets the accepted message
// - Any unused character rejects the message
// - Out-of-order correct character rejects the message
// - Slot timing up to 25.71 ms accepted
// - First command latches arm and engine cutoff
// - Dispersion command fires discharge trigger pulse once armed
// - Trigger passes only with inhibit released
// - Power-transfer command latches internal power
// - Safe command returns power to external
// - Once safed, no command is accepted
// - No-safing strap makes safe command inert
// - Power-on status asserted from reset until safed
module scd_decoder_ctrl #(
  parameter int unsigned SLOT_TIMEOUT_CYC = scd_pkg::SLOT_TIMEOUT_CYC,
  parameter int unsigned FIRE_PULSE_CYC = scd_pkg::FIRE_PULSE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Receiver tone levels and code plug
  input wire logic [scd_pkg::NUM_TONES-1:0] tones,
  input wire scd_pkg::scd_plug_t plug,
  // Interlock pins
  input wire logic dispersion_inhibit,
  input wire logic no_safing,
  // Actions toward detonator_firing_unit, cutoff and relays
  output scd_pkg::scd_out_t actions,
  // Decoder status
  output logic msg_reject,
  output logic [scd_pkg::NUM_CMDS-1:0] cmd_hit
);

  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_ADDR = 3'b010,
    ST_FUNC = 3'b100
  } scd_state_t;

  scd_state_t state_r;
  logic [3:0] pos_r;
  logic [scd_pkg::NUM_CMDS-1:0] cand_r;
  scd_pkg::scd_char_t first_fc_r;
  logic [31:0] slot_cnt_r;
  logic any_prev_r;
  logic reject_r;
  logic [scd_pkg::NUM_CMDS-1:0] hit_r;
  logic arm_r;
  logic internal_r;
  logic safed_r;
  logic power_on_r;
  logic fire_r;

  logic [scd_pkg::NUM_TONES+1:0] pins_s;
  logic [scd_pkg::NUM_TONES-1:0] tones_s;
  logic inhibit_s;
  logic no_safe_s;
  logic [5:0] dec;
  logic ch_valid;
  scd_pkg::scd_char_t ch;
  logic ch_any;
  logic onset;
  logic ch_in_code;
  logic timeout;
  logic fire_active;
  logic [scd_pkg::NUM_CMDS-1:0] cand0;
  logic [scd_pkg::NUM_CMDS-1:0] cand1;

  scd_sync3 #(
    .W(scd_pkg::NUM_TONES + 2)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d({no_safing, dispersion_inhibit, tones}),
    .q(pins_s)
  );

  assign tones_s = pins_s[scd_pkg::NUM_TONES-1:0];
  assign inhibit_s = pins_s[scd_pkg::NUM_TONES];
  assign no_safe_s = pins_s[scd_pkg::NUM_TONES+1];

  assign dec = scd_pkg::scd_decode_tones(tones_s);
  assign ch_valid = dec[5];
  assign ch = dec[4:0];
  assign ch_any = |tones_s;
  // A character counts once, on the edge out of dead time
  assign onset = ch_any && !any_prev_r;
  assign ch_in_code = ch_valid && scd_pkg::scd_in_code(plug, ch);
  // Slot reaching SLOT_TIMEOUT_CYC cycles (30 ms, above the longest legal slot) abandons the message
  assign timeout = (state_r != ST_HUNT) && (slot_cnt_r >= SLOT_TIMEOUT_CYC - 1);

  always_comb
  begin
    cand0 = '0;
    cand1 = '0;
    for (int k = 0; k < scd_pkg::NUM_CMDS; k++)
    begin
      cand0[k] = (plug.func[k][0] == ch);
      cand1[k] = cand_r[k] && (plug.func[k][1] == ch);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      any_prev_r <= 1'b0;
    end
    else
    begin
      any_prev_r <= ch_any;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r == ST_HUNT || onset)
    begin
      slot_cnt_r <= 32'h0;
    end
    else
    begin
      slot_cnt_r <= slot_cnt_r + 32'h1;
    end
  end

  // Message sequencer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r <= ST_HUNT;
      pos_r <= scd_pkg::POS_RST;
      cand_r <= '0;
      first_fc_r <= '0;
      reject_r <= 1'b0;
      hit_r <= '0;
    end
    else
    begin
      reject_r <= 1'b0;
      hit_r <= '0;
      if (safed_r)
      begin
        state_r <= ST_HUNT;
        pos_r <= scd_pkg::POS_RST;
      end
      else if (timeout)
      begin
        state_r <= ST_HUNT;
        pos_r <= scd_pkg::POS_RST;
      end
      else if (onset)
      begin
        unique case (state_r)
          ST_HUNT:
          begin
            if (ch_valid && ch == plug.addr[0])
            begin
              state_r <= ST_ADDR;
              pos_r <= scd_pkg::POS_FIRST + 4'h1;
            end
          end
          ST_ADDR:
          begin
            if (!ch_in_code || ch != plug.addr[pos_r])
            begin
              reject_r <= 1'b1;
              state_r <= ST_HUNT;
              pos_r <= scd_pkg::POS_RST;
            end
            else if (pos_r == scd_pkg::POS_LAST_ADDR)
            begin
              state_r <= ST_FUNC;
              pos_r <= scd_pkg::POS_FUNC0;
            end
            else
            begin
              pos_r <= pos_r + 4'h1;
            end
          end
          ST_FUNC:
          begin
            if (!ch_in_code)
            begin
              reject_r <= 1'b1;
              state_r <= ST_HUNT;
              pos_r <= scd_pkg::POS_RST;
            end
            else if (pos_r == scd_pkg::POS_FUNC0)
            begin
              if (cand0 == '0)
              begin
                reject_r <= 1'b1;
                state_r <= ST_HUNT;
                pos_r <= scd_pkg::POS_RST;
              end
              else
              begin
                cand_r <= cand0;
                first_fc_r <= ch;
                pos_r <= scd_pkg::POS_FUNC1;
              end
            end
            else
            begin
              if (ch == first_fc_r || cand1 == '0)
              begin
                reject_r <= 1'b1;
              end
              else
              begin
                hit_r <= cand1;
              end
              state_r <= ST_HUNT;
              pos_r <= scd_pkg::POS_RST;
            end
          end
        endcase
      end
    end
  end

  // Arm and cutoff latch; only reset clears it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      arm_r <= 1'b0;
    end
    else if (hit_r[scd_pkg::CMD_ARM])
    begin
      arm_r <= 1'b1;
    end
  end

  // Power relay and safing; the safe term outranks transfer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      internal_r <= 1'b0;
      safed_r <= 1'b0;
      power_on_r <= scd_pkg::POWER_ON_RST;
    end
    else if (hit_r[scd_pkg::CMD_SAFE] && !no_safe_s)
    begin
      internal_r <= 1'b0;
      safed_r <= 1'b1;
      power_on_r <= 1'b0;
    end
    else if (hit_r[scd_pkg::CMD_PWR])
    begin
      internal_r <= 1'b1;
    end
  end

  // Discharge only makes sense once the charge circuit is armed
  scd_pulse_timer #(
    .LEN_CYC(FIRE_PULSE_CYC)
  ) u_fire (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(hit_r[scd_pkg::CMD_DISP] && arm_r),
    .active(fire_active)
  );

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      fire_r <= 1'b0;
    end
    else
    begin
      fire_r <= fire_active && !inhibit_s;
    end
  end

  assign actions.arm_cutoff = arm_r;
  assign actions.fire_trigger = fire_r;
  assign actions.internal_power = internal_r;
  assign actions.power_on = power_on_r;
  assign actions.safed = safed_r;
  assign msg_reject = reject_r;
  assign cmd_hit = hit_r;

  property p_arm_hold;
    @(posedge ref_clk) disable iff (srst) arm_r |=> arm_r;
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("arm latch dropped");

  property p_hit_after_func;
    @(posedge ref_clk) disable iff (srst)
      (hit_r != '0) |-> $past(state_r == ST_FUNC && pos_r == scd_pkg::POS_FUNC1);
  endproperty
  a_hit_after_func: assert property (p_hit_after_func) else $error("command without address");

  property p_unused_rejects;
    @(posedge ref_clk) disable iff (srst)
      (onset && state_r != ST_HUNT && !ch_in_code && !safed_r && !timeout)
        |=> msg_reject && state_r == ST_HUNT;
  endproperty
  a_unused_rejects: assert property (p_unused_rejects) else $error("unused char accepted");

  property p_order_rejects;
    @(posedge ref_clk) disable iff (srst)
      (onset && state_r == ST_ADDR && ch_in_code && ch != plug.addr[pos_r] && !safed_r
        && !timeout) |=> msg_reject ##1 !msg_reject;
  endproperty
  a_order_rejects: assert property (p_order_rejects) else $error("order error missed");

  property p_fire_gated;
    @(posedge ref_clk) disable iff (srst) fire_r |-> $past(!inhibit_s);
  endproperty
  a_fire_gated: assert property (p_fire_gated) else $error("fired under inhibit");

  property p_fire_starts;
    @(posedge ref_clk) disable iff (srst)
      (hit_r[scd_pkg::CMD_DISP] && arm_r) ##1 !inhibit_s |=> fire_r;
  endproperty
  a_fire_starts: assert property (p_fire_starts) else $error("trigger not issued");

  property p_safed_dead;
    @(posedge ref_clk) disable iff (srst)
      safed_r |=> safed_r && hit_r == '0 && state_r == ST_HUNT;
  endproperty
  a_safed_dead: assert property (p_safed_dead) else $error("safed system active");

  property p_safe_power;
    @(posedge ref_clk) disable iff (srst)
      hit_r[scd_pkg::CMD_SAFE] && !no_safe_s |=> !internal_r && !power_on_r;
  endproperty
  a_safe_power: assert property (p_safe_power) else $error("safe left power");

  property p_no_safing;
    @(posedge ref_clk) disable iff (srst)
      hit_r[scd_pkg::CMD_SAFE] && no_safe_s && !safed_r |=> !safed_r && power_on_r;
  endproperty
  a_no_safing: assert property (p_no_safing) else $error("safe acted when strapped");

  property p_power_xfer;
    @(posedge ref_clk) disable iff (srst)
      hit_r[scd_pkg::CMD_PWR] && !hit_r[scd_pkg::CMD_SAFE] |=> internal_r;
  endproperty
  a_power_xfer: assert property (p_power_xfer) else $error("transfer not latched");

  property p_power_on;
    @(posedge ref_clk) disable iff (srst) !safed_r |-> power_on_r;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on status low");

  property p_timeout;
    @(posedge ref_clk) disable iff (srst)
      timeout && !safed_r |=> state_r == ST_HUNT && pos_r == scd_pkg::POS_RST;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout kept progress");

  c_arm: cover property (@(posedge ref_clk) disable iff (srst) $rose(arm_r));
  c_fire: cover property (@(posedge ref_clk) disable iff (srst) $rose(fire_r));
  c_safe: cover property (@(posedge ref_clk) disable iff (srst) $rose(safed_r));
  c_reject: cover property (@(posedge ref_clk) disable iff (srst) msg_reject);

endmodule
`default_nettype wire

/* tb/scd_ground_encoder.sv */
// Purpose: Ground encoder model feeding demodulated tone levels to the decoder
// Assumes: Levels change just after a rising edge of ref_clk
// Notes: Slot lengths are shortened; last slot keeps a longer dead time
`timescale 1ns/1ps
`default_nettype none
module scd_ground_encoder #(
  parameter int ON_CYC = 6,
  parameter int OFF_CYC = 6,
  parameter int LAST_OFF_CYC = 20
) (
  // Clock
  input wire logic ref_clk,
  // Tone levels toward the receiver output
  output var logic [6:0] tones
);
  initial tones = 7'h00;

  // Character index enumerates tone pairs i<j in order
  function automatic logic [6:0] pair_of(input logic [4:0] c);
    logic [6:0] p;
    int k;
    p = 7'h00;
    k = 0;
    for (int i = 0; i < 7; i++)
    begin
      for (int j = i + 1; j < 7; j++)
      begin
        if (k == int'(c))
        begin
          p = (7'h01 << i) | (7'h01 << j);
        end
        k++;
      end
    end
    return p;
  endfunction

  // One burst then dead time, so each character has its own onset
  task automatic send_pattern(input logic [6:0] p, input int off);
    @(posedge ref_clk);
    tones <= p;
    repeat (ON_CYC) @(posedge ref_clk);
    tones <= 7'h00;
    repeat (off) @(posedge ref_clk);
  endtask

  // Nine address then two function characters, longer final slot
  task automatic send_msg(input logic [10:0][4:0] m);
    for (int i = 0; i < 11; i++)
    begin
      send_pattern(pair_of(m[i]), (i == 10) ? LAST_OFF_CYC : OFF_CYC);
    end
  endtask

  // Ten identical copies back to back, so one intact copy gets through
  task automatic send_frame(input logic [10:0][4:0] m);
    for (int n = 0; n < 10; n++)
    begin
      send_msg(m);
    end
  endtask
endmodule
`default_nettype wire

/* tb/scd_decoder_ctrl_bench.sv */
// Purpose: Self-checking bench for the command decoder and controller
// Assumes: Plug is static; shortened timeout and fire pulse
// Notes: Gap between messages exceeds the slot timeout to flush partials
`timescale 1ns/1ps
`default_nettype none
module scd_decoder_ctrl_bench;
  localparam int TMO = 200;
  localparam int FIRE = 8;
  localparam int GAP = 250;
  localparam logic [44:0] ADDR_W = {5'h14, 5'h09, 5'h0e, 5'h05, 5'h13, 5'h01, 5'h0c, 5'h07, 5'h03};
  localparam logic [39:0] FUNC_W = {5'h09, 5'h0e, 5'h05, 5'h13, 5'h01, 5'h0c, 5'h07, 5'h03};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] tones;
  scd_pkg::scd_plug_t plug = scd_pkg::scd_plug_t'({ADDR_W, FUNC_W});
  logic dispersion_inhibit = 1'b1;
  logic no_safing = 1'b1;
  scd_pkg::scd_out_t actions;
  logic msg_reject;
  logic [3:0] cmd_hit;
  logic clr = 1'b0;
  logic [3:0] seen_hit = 4'h0;
  logic seen_rej = 1'b0;
  logic [15:0] fire_cnt = 16'h0000;
  int n_errors = 0;
  int checked = 0;
  logic [10:0][4:0] row_msg [8];
  logic [3:0] row_hit [8];
  logic row_rej [8];
  logic [10:0][4:0] m;

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  scd_ground_encoder i_scd_ground_encoder (
    .ref_clk(ref_clk),
    .tones(tones)
  );

  scd_decoder_ctrl #(.SLOT_TIMEOUT_CYC(TMO), .FIRE_PULSE_CYC(FIRE)) i_scd_decoder_ctrl (
    .ref_clk(ref_clk),
    .srst(srst),
    .tones(tones),
    .plug(plug),
    .dispersion_inhibit(dispersion_inhibit),
    .no_safing(no_safing),
    .actions(actions),
    .msg_reject(msg_reject),
    .cmd_hit(cmd_hit)
  );

  // Hit and reject pulses are one cycle wide, so accumulate them per message
  always @(posedge ref_clk)
  begin
    if (clr)
    begin
      seen_hit <= 4'h0;
      seen_rej <= 1'b0;
      fire_cnt <= 16'h0000;
    end
    else
    begin
      seen_hit <= seen_hit | cmd_hit;
      seen_rej <= seen_rej | msg_reject;
      fire_cnt <= fire_cnt + {15'h0000, actions.fire_trigger};
    end
  end

  function automatic logic [10:0][4:0] mk(input logic [4:0] f0, input logic [4:0] f1);
    return {f1, f0, ADDR_W};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Counters are cleared, then the message runs and the line idles
  task automatic run_msg(input logic [10:0][4:0] msg);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    i_scd_ground_encoder.send_msg(msg);
    repeat (GAP) @(posedge ref_clk);
  endtask

  task automatic expect_msg(input logic [3:0] hit, input logic rej, input logic [15:0] fires);
    check({12'h000, seen_hit}, {12'h000, hit}, "command hits");
    check({15'h0000, seen_rej}, {15'h0000, rej}, "reject");
    check(fire_cnt, fires, "fire cycles");
  endtask

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    $display("BAD t=%0t run did not finish", $time);
    conclude();
  end

  initial
  begin
    row_msg[0] = mk(5'h0c, 5'h01); row_hit[0] = 4'h2; row_rej[0] = 1'b0;
    row_msg[1] = mk(5'h03, 5'h07); row_hit[1] = 4'h1; row_rej[1] = 1'b0;
    row_msg[2] = mk(5'h07, 5'h03); row_hit[2] = 4'h0; row_rej[2] = 1'b1;
    row_msg[3] = mk(5'h03, 5'h03); row_hit[3] = 4'h0; row_rej[3] = 1'b1;
    m = mk(5'h03, 5'h07); m[4] = 5'h05; m[5] = 5'h13;
    row_msg[4] = m; row_hit[4] = 4'h0; row_rej[4] = 1'b1;
    m = mk(5'h03, 5'h07); m[2] = 5'h00;
    row_msg[5] = m; row_hit[5] = 4'h0; row_rej[5] = 1'b1;
    row_msg[6] = mk(5'h13, 5'h05); row_hit[6] = 4'h4; row_rej[6] = 1'b0;
    row_msg[7] = mk(5'h03, 5'h07); row_hit[7] = 4'h1; row_rej[7] = 1'b0;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    check({11'h000, actions}, 16'h0002, "reset actions");
    check({15'h0000, msg_reject}, 16'h0000, "reset reject");
    check({12'h000, cmd_hit}, 16'h0000, "reset hits");
    for (int r = 0; r < 8; r++)
    begin
      run_msg(row_msg[r]);
      expect_msg(row_hit[r], row_rej[r], 16'h0000);
    end
    check({15'h0000, actions.arm_cutoff}, 16'h0001, "arm latch");
    check({15'h0000, actions.internal_power}, 16'h0001, "power latch");
    // Inhibit released: a full trigger pulse
    @(posedge ref_clk);
    dispersion_inhibit <= 1'b0;
    run_msg(mk(5'h0c, 5'h01));
    expect_msg(4'h2, 1'b0, 16'(FIRE));
    // A whole frame: every copy decodes and fires its own pulse
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    i_scd_ground_encoder.send_frame(mk(5'h0c, 5'h01));
    repeat (GAP) @(posedge ref_clk);
    expect_msg(4'h2, 1'b0, 16'(10 * FIRE));
    // Three tones at once mid-message
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    i_scd_ground_encoder.send_pattern(i_scd_ground_encoder.pair_of(5'h03), 6);
    i_scd_ground_encoder.send_pattern(i_scd_ground_encoder.pair_of(5'h07), 6);
    i_scd_ground_encoder.send_pattern(7'h07, 6);
    repeat (GAP) @(posedge ref_clk);
    expect_msg(4'h0, 1'b1, 16'h0000);
    // Partial address left to time out, then a clean message
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      i_scd_ground_encoder.send_pattern(i_scd_ground_encoder.pair_of(ADDR_W[i*5 +: 5]), 6);
    end
    repeat (GAP) @(posedge ref_clk);
    i_scd_ground_encoder.send_msg(mk(5'h13, 5'h05));
    repeat (GAP) @(posedge ref_clk);
    expect_msg(4'h4, 1'b0, 16'h0000);
    // Safe command with the no-safing strap fitted
    run_msg(mk(5'h0e, 5'h09));
    expect_msg(4'h8, 1'b0, 16'h0000);
    check({11'h000, actions}, 16'h0016, "strap keeps power");
    @(posedge ref_clk);
    no_safing <= 1'b0;
    run_msg(mk(5'h0e, 5'h09));
    expect_msg(4'h8, 1'b0, 16'h0000);
    check({15'h0000, actions.safed}, 16'h0001, "safed");
    check({15'h0000, actions.internal_power}, 16'h0000, "power external");
    check({15'h0000, actions.power_on}, 16'h0000, "power status off");
    // Nothing is accepted once safed
    run_msg(mk(5'h13, 5'h05));
    expect_msg(4'h0, 1'b0, 16'h0000);
    run_msg(mk(5'h0c, 5'h01));
    expect_msg(4'h0, 1'b0, 16'h0000);
    check({15'h0000, actions.internal_power}, 16'h0000, "stays external");
    // Only reset revives a safed system, with every latch at its idle value
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    check({11'h000, actions}, 16'h0002, "second reset actions");
    run_msg(mk(5'h13, 5'h05));
    expect_msg(4'h4, 1'b0, 16'h0000);
    check({11'h000, actions}, 16'h0006, "transfer after reset");
    conclude();
  end
endmodule
`default_nettype wire
